//--- src/opc_defs.vh
// Register offsets, field positions, reset values and timing constants
`ifndef OPC_DEFS_VH
`define OPC_DEFS_VH
`define OPC_ADDR_HSTART 8'hc3
`define OPC_ADDR_PLL 8'hc4
`define OPC_ADDR_FIRSTADDR 8'hc5
`define OPC_ADDR_CTRL2 8'hcf
`define OPC_HSTART_RST 8'h12
`define OPC_PLL_RST 8'h00
`define OPC_FIRST_RST 8'h00
`define OPC_FIRST_MAX 8'hbf
`define OPC_CTRL2_RST 8'h02
`define OPC_CTRL2_TEST_CODE_ENABLE 4
`define OPC_CTRL2_RGB_HI 3
`define OPC_CTRL2_RGB_LO 1
`define OPC_PLL_BASE 10'h081
`define OPC_HS_MULT 2
`define OPC_ROW_LEN 11'h0c0
`define OPC_PHASE_W 24
`define OPC_SYS_HZ 50000000
`endif

//--- src/opc_dds.v
// Numerically controlled dot-clock generator locked to sync edges
`timescale 1ns/1ps
`include "opc_defs.vh"
module opc_dds (
  input wire i_clk,              // System clock
  input wire i_rstn,             // Synchronous reset, active low
  input wire i_hs_edge,          // Corrected sync leading edge pulse
  input wire [7:0] i_pll_setting, // Dot clock setting
  output reg o_tick              // One pulse per dot clock period
);
  reg [`OPC_PHASE_W-1:0] phase;
  reg [`OPC_PHASE_W-1:0] next_phase;
  reg [23:0] line_cnt;
  reg [9:0] dots_per_line;
  reg [33:0] prod;
  reg [33:0] quot;
  reg [`OPC_PHASE_W:0] sum;
  // Phase step = 2*(129+setting)*2^W/line_len, refreshed each line
  reg [`OPC_PHASE_W-1:0] step;
  always @*
  begin
    dots_per_line = (`OPC_PLL_BASE + {2'h0, i_pll_setting}) << 1;
    prod = {dots_per_line, 24'h000000};
    // Guard keeps the divider defined before the first full line
    quot = (line_cnt == 24'h000000) ? 34'h000000000 : prod / {10'h000, line_cnt};
    sum = {1'b0, phase} + {1'b0, step};
    next_phase = sum[`OPC_PHASE_W-1:0];
  end
  always @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      phase <= 24'h000000;
      line_cnt <= 24'h000000;
      step <= 24'h000000;
      o_tick <= 1'b0;
    end
    else if (i_hs_edge)
    begin
      phase <= 24'h000000;
      line_cnt <= 24'h000001;
      step <= quot[`OPC_PHASE_W-1:0];
      o_tick <= 1'b1;
    end
    else
    begin
      phase <= next_phase;
      if (line_cnt != 24'hffffff)
        line_cnt <= line_cnt + 24'h000001;
      o_tick <= sum[`OPC_PHASE_W];
    end
  end
endmodule // opc_dds

//--- src/opc_top.v
// OSD horizontal start, RAM start, frame colour and dot clock slice
// Behaviour
// - Seven-bit horizontal start, top bit unused
// - Display begins after twice start dot clocks, 256 when start is zero
// - First fetch address from start register, 0-191
// - Test code shows space ROM patterns
// - Bits 3..1 frame colour, blue at reset
// - Reserved control bits have no effect
// - Dot clock 2*fh*(129+setting)
// - Dot clock 4-12 MHz, 31.25 kHz steps
// - Loop references polarity-corrected sync
// - Setting register resets to zero
// - Colour bits are red green blue enables
// - Frame mode blanking active on scan lines
// - Polarity bit selects sync active level
`timescale 1ns/1ps
`include "opc_defs.vh"
module opc_top (
  input wire i_clk,                // 50 MHz system clock
  input wire i_rstn,               // Synchronous reset, active low
  input wire i_sfr_wr,             // Register write strobe
  input wire i_sfr_rd,             // Register read strobe
  input wire [7:0] i_sfr_addr,     // Register address
  input wire [7:0] i_sfr_wdata,    // Register write data
  input wire i_hsync,              // Horizontal sync pin
  input wire i_vsync,              // Vertical sync pin
  input wire i_hsync_polarity_select, // High: sync active high
  input wire i_vsync_polarity_select, // High: vsync active high
  input wire i_frame_mode,         // High: frame background mode
  input wire i_row_done,           // Renderer finished character row
  output reg [7:0] o_sfr_rdata,    // Register read data
  output reg o_sfr_hit,            // Read address decoded
  output reg o_dot_tick,           // Dot clock pulse
  output reg o_row_start,          // Character display start pulse
  output reg [7:0] o_first_addr,   // First display RAM address
  output reg o_test_code_enable,   // Space codes show ROM pattern
  output reg [2:0] o_frame_rgb,    // Frame background red green blue
  output reg o_fast_blanking_output, // Fast blanking, active high
  output reg o_polarity_corrected_hsync // Corrected sync level
);
  reg [7:0] horizontal_start_position;
  reg [7:0] dot_clock_pll_setting;
  reg [7:0] display_ram_first_address;
  reg [7:0] overlay_control_two;
  reg [1:0] hs_sync;
  reg [1:0] vs_sync;
  reg hs_prev;
  reg vs_prev;
  wire hs_level;
  wire vs_level;
  wire hs_edge;
  wire tick;
  reg [7:0] dot_cnt;
  reg counting;
  reg in_vretrace;
  reg in_hretrace;
  reg [7:0] next_rdata;
  reg next_hit;
  wire [7:0] start_dots;
  // Two-stage synchronisers; only stage two feeds logic
  always @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      hs_sync <= 2'h0;
      vs_sync <= 2'h0;
    end
    else
    begin
      hs_sync <= {hs_sync[0], i_hsync};
      vs_sync <= {vs_sync[0], i_vsync};
    end
  end
  assign hs_level = i_hsync_polarity_select ? hs_sync[1] : ~hs_sync[1];
  assign vs_level = i_vsync_polarity_select ? vs_sync[1] : ~vs_sync[1];
  assign hs_edge = hs_level & ~hs_prev;
  opc_dds u_dds (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_hs_edge(hs_edge),
    .i_pll_setting(dot_clock_pll_setting),
    .o_tick(tick)
  );
  // Register writes
  always @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      horizontal_start_position <= `OPC_HSTART_RST;
      dot_clock_pll_setting <= `OPC_PLL_RST;
      display_ram_first_address <= `OPC_FIRST_RST;
      overlay_control_two <= `OPC_CTRL2_RST;
    end
    else if (i_sfr_wr)
    begin
      case (i_sfr_addr)
        `OPC_ADDR_HSTART: horizontal_start_position <= {1'b0, i_sfr_wdata[6:0]};
        `OPC_ADDR_PLL: dot_clock_pll_setting <= i_sfr_wdata;
        `OPC_ADDR_FIRSTADDR: display_ram_first_address <= i_sfr_wdata;
        `OPC_ADDR_CTRL2: overlay_control_two <= {3'h0, i_sfr_wdata[4:1], 1'b0};
        default: ;
      endcase
    end
  end
  always @*
  begin
    next_hit = 1'b1;
    case (i_sfr_addr)
      `OPC_ADDR_HSTART: next_rdata = horizontal_start_position;
      `OPC_ADDR_PLL: next_rdata = dot_clock_pll_setting;
      `OPC_ADDR_FIRSTADDR: next_rdata = display_ram_first_address;
      `OPC_ADDR_CTRL2: next_rdata = overlay_control_two;
      default:
      begin
        next_rdata = 8'h00;
        next_hit = 1'b0;
      end
    endcase
  end
  assign start_dots = {horizontal_start_position[6:0], 1'b0};
  // Start counter runs on dot ticks, restarted on each sync edge
  always @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      hs_prev <= 1'b0;
      vs_prev <= 1'b0;
      dot_cnt <= 8'h00;
      counting <= 1'b0;
      in_vretrace <= 1'b0;
      in_hretrace <= 1'b0;
      o_row_start <= 1'b0;
      o_dot_tick <= 1'b0;
      o_sfr_rdata <= 8'h00;
      o_sfr_hit <= 1'b0;
      o_first_addr <= 8'h00;
      o_test_code_enable <= 1'b0;
      o_frame_rgb <= 3'h1;
      o_fast_blanking_output <= 1'b0;
      o_polarity_corrected_hsync <= 1'b0;
    end
    else
    begin
      hs_prev <= hs_level;
      vs_prev <= vs_level;
      in_vretrace <= vs_level;
      in_hretrace <= hs_level;
      o_dot_tick <= tick;
      o_polarity_corrected_hsync <= hs_level;
      o_sfr_rdata <= i_sfr_rd ? next_rdata : 8'h00;
      o_sfr_hit <= i_sfr_rd & next_hit;
      // Out-of-range start address is clamped to the last location
      o_first_addr <= (display_ram_first_address > `OPC_FIRST_MAX) ?
        `OPC_FIRST_MAX : display_ram_first_address;
      o_test_code_enable <= overlay_control_two[`OPC_CTRL2_TEST_CODE_ENABLE];
      o_frame_rgb <= overlay_control_two[`OPC_CTRL2_RGB_HI:`OPC_CTRL2_RGB_LO];
      o_row_start <= 1'b0;
      if (hs_edge)
      begin
        dot_cnt <= 8'h00;
        counting <= 1'b1;
      end
      else if (counting && tick)
      begin
        if (dot_cnt + 8'h01 == start_dots)
        begin
          counting <= 1'b0;
          o_row_start <= 1'b1;
        end
        dot_cnt <= dot_cnt + 8'h01;
      end
      o_fast_blanking_output <= i_frame_mode & ~hs_level & ~vs_level;
    end
  end
endmodule // opc_top

//--- verification/opc_sync_model.sv
// Horizontal and vertical sync source seen by the slice
`timescale 1ns/1ps
module opc_sync_model #(parameter int PER = 3200) (
  input wire logic i_clk, // System clock
  input wire logic i_pol, // Active level of the sync pulse
  output logic o_hsync, // Horizontal sync pin
  output logic o_vsync // Vertical sync pin, never active
);
  int cnt = 0;
  assign o_vsync = 1'b1;
  always @(negedge i_clk)
  begin
    cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
    o_hsync <= i_pol ~^ (cnt < 235);
  end
endmodule // opc_sync_model

//--- verification/opc_top_monitor.sv
// Checker of the OSD position and clock slice ports
`timescale 1ns/1ps
module opc_top_monitor (
  input wire logic i_clk, i_rstn, i_sfr_wr, i_sfr_rd, // Clock, reset, strobes
  input wire logic [7:0] i_sfr_addr, i_sfr_wdata, // Bus address, data
  input wire logic i_hsync, i_hsync_polarity_select, i_frame_mode, // Sync
  input wire logic [7:0] o_sfr_rdata, o_first_addr, // Read data, address
  input wire logic o_row_start, o_test_code_enable, o_fast_blanking_output, // Flags
  input wire logic [2:0] o_frame_rgb, // Frame colour
  input wire logic o_polarity_corrected_hsync // Corrected sync
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  chk_hstart_top_bit: assert property (i_sfr_rd && i_sfr_addr == 8'hc3 |=> !o_sfr_rdata[7])
    else $error("start bit 7 read high");
  chk_ctrl_reserved: assert property (i_sfr_rd && i_sfr_addr == 8'hcf |=> o_sfr_rdata[0] == 1'b0
    && o_sfr_rdata[7:5] == 3'h0)
    else $error("reserved bits read high");
  chk_first_range: assert property (o_first_addr <= 8'hbf)
    else $error("first address out of range");
  chk_test_code: assert property (i_sfr_wr && i_sfr_addr == 8'hcf |-> ##2
    o_test_code_enable == $past(i_sfr_wdata[4], 2)) else $error("test code wrong");
  chk_frame_colour: assert property (i_sfr_wr && i_sfr_addr == 8'hcf |-> ##2
    o_frame_rgb == $past(i_sfr_wdata[3:1], 2)) else $error("frame colour wrong");
  chk_reset_blue: assert property (disable iff (1'b0) !i_rstn |=> o_frame_rgb == 3'h1)
    else $error("colour not blue at reset");
  chk_blank_off: assert property ((!i_frame_mode) [*4] |=> !o_fast_blanking_output)
    else $error("blanking without frame mode");
  chk_sync_level: assert property (($stable(i_hsync) && $stable(i_hsync_polarity_select)) [*4]
    |-> o_polarity_corrected_hsync == (i_hsync ~^ i_hsync_polarity_select))
    else $error("corrected sync level wrong");
  chk_row_pulse: assert property (o_row_start |=> !o_row_start)
    else $error("row start longer than a cycle");
  cover property (o_row_start);
  cover property (i_sfr_wr && i_sfr_addr == 8'hcf);
  cover property (o_fast_blanking_output);
endmodule // opc_top_monitor

//--- verification/testbench.sv
// Self-checking bench for the OSD position and clock slice
`timescale 1ns/1ps
module testbench;
  logic i_clk = 0, i_rstn = 0, i_sfr_wr = 0, i_sfr_rd = 0, pol = 1, frame = 1;
  logic [7:0] addr = 8'h00, wdata = 8'h00;
  wire hs, vs, hit, tick, rs, tce, fb, chs;
  wire [7:0] rdata, first;
  wire [2:0] rgb;
  int n_mismatch = 0, n_compared = 0;
  always #10 i_clk = ~i_clk;
  opc_sync_model SYN (.i_clk(i_clk), .i_pol(pol), .o_hsync(hs), .o_vsync(vs));
  opc_top DUT (.i_clk(i_clk), .i_rstn(i_rstn), .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd),
    .i_sfr_addr(addr), .i_sfr_wdata(wdata), .i_hsync(hs), .i_vsync(vs),
    .i_hsync_polarity_select(pol), .i_vsync_polarity_select(1'b0), .i_frame_mode(frame),
    .i_row_done(1'b0), .o_sfr_rdata(rdata), .o_sfr_hit(hit), .o_dot_tick(tick),
    .o_row_start(rs), .o_first_addr(first), .o_test_code_enable(tce), .o_frame_rgb(rgb),
    .o_fast_blanking_output(fb), .o_polarity_corrected_hsync(chs));
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(negedge i_clk);
    {i_sfr_wr, addr, wdata} = {1'b1, a, d};
    @(negedge i_clk);
    i_sfr_wr = 0;
    repeat (2) @(negedge i_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [8:0] exp);
    @(negedge i_clk);
    {i_sfr_rd, addr} = {1'b1, a};
    @(negedge i_clk);
    i_sfr_rd = 0;
    chk("read", {hit, rdata}, exp);
  endtask
  // Program a line, wait three sync edges to relock, then count ticks
  task automatic run(input logic [7:0] pll, hp, input logic p, f);
    int n;
    int s;
    wr(8'hc4, pll);
    wr(8'hc3, hp);
    {pol, frame} = {p, f};
    repeat (3) @(posedge chs);
    @(negedge i_clk);
    chk("blank", fb, 0);
    n = 0;
    s = 0;
    do
    begin
      @(negedge i_clk);
      n += tick;
      if (rs)
      begin
        s = n;
        chk("fb", fb, f);
      end
    end
    while (!(chs && n > 130));
    chk("ticks", n, 2 * (129 + pll));
    chk("start", s, 2 * hp);
  endtask
  task automatic results();
    if (n_mismatch == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge i_clk);
    n_mismatch++;
    results();
  end
  initial
  begin
    repeat (20) @(negedge i_clk);
    i_rstn = 1;
    chk("rgb", rgb, 3'h1);
    chk("tce", tce, 0);
    rd(8'hc3, 9'h112);
    rd(8'hc4, 9'h100);
    rd(8'hc5, 9'h100);
    rd(8'hcf, 9'h102);
    rd(8'hc0, 9'h000);
    wr(8'hc3, 8'hff);
    rd(8'hc3, 9'h17f);
    wr(8'hcf, 8'hff);
    rd(8'hcf, 9'h11e);
    chk("tce", tce, 1);
    for (int i = 0; i < 8; i++)
    begin
      wr(8'hcf, {4'he, i[2:0], 1'b1});
      chk("rgb", rgb, i[2:0]);
      chk("tce", tce, 0);
    end
    wr(8'hc5, 8'h05);
    chk("first", first, 8'h05);
    wr(8'hc5, 8'hbf);
    chk("first", first, 8'hbf);
    wr(8'hc5, 8'hc0);
    chk("first", first, 8'hbf);
    rd(8'hc5, 9'h1c0);
    wr(8'hc6, 8'h55);
    rd(8'hc4, 9'h100);
    run(8'h00, 8'h12, 1, 1);
    run(8'h7f, 8'h20, 0, 1);
    run(8'hff, 8'h12, 1, 0);
    results();
  end
endmodule // testbench
bind opc_top opc_top_monitor u_mon (.*);
